// ### logic/fsc_regs.sv
// Flash security, index and configuration registers with APB slave and interrupt
//
// Functional notes
// - Security register is fully readable; software writes to it are ignored.
// - At reset the security register loads the security byte from flash.
// - Double-bit fault on that load sets every security bit to one.
// - Backdoor key access enabled only when bits 7:6 hold 10.
// - Security field bits 1:0 mean unsecured only for 10.
// - Backdoor unsecure forces the security field to 10.
// - Command index bits 2:0 select command word; other bits read zero.
// - ECC index bits 2:0 select ECC result word; other bits read zero.
// - Command-complete flag raises interrupt only while its enable is one.
// - Ignore-single-fault suppresses single fault flag and its interrupt.
// - Force-double makes every array read set the double fault flag.
// - Under forced double, ECC results update only on a real double fault; here a real single fault also updates them unless ignore-single-fault is one.
// - Force-single makes every array read set the single fault flag while ignore-single-fault is zero.
// - Under forced single, ECC results update only on a real single fault; here a real double fault also updates them.
// - Only enable, ignore and force bits of config are writable.
// - Command-complete flag is zero while busy; writing one launches.
// - Fault flags raise interrupt while their enable bits are one.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "fsc_map.svh"

module fsc_regs (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Security byte fetch during reset sequence
    output logic             NVM_REQ,
    output logic      [22:0] NVM_ADDR,
    input  wire logic        NVM_ACK,
    input  wire logic [7:0]  NVM_DATA,
    input  wire logic        NVM_DBE,
    input  wire logic        BACKDOOR_UNSEC,
    output logic             SECURED,
    output logic             BACKDOOR_EN,
    // Command sequencer
    output logic             CMD_LAUNCH,
    input  wire logic        CMD_DONE,
    output logic      [2:0]  CMD_INDEX,
    // Array read path with ECC checker
    input  wire logic        RD_VALID,
    input  wire logic        RD_SBE,
    input  wire logic        RD_DBE,
    output logic             ECC_UPDATE,
    output logic      [2:0]  ECC_INDEX,
    // Interrupt
    output logic             IRQ
);

    // ======================================================================
    // Helper functions

    // Register index from a byte address
    function automatic logic [5:0] reg_index(input logic [7:0] addr);
        reg_index = addr[7:2];
    endfunction : reg_index

    // Whether an index hits an implemented register
    function automatic logic is_mapped(input logic [5:0] ix);
        is_mapped = (ix == `FSC_IDX_SEC)     || (ix == `FSC_IDX_CMD_IX)  ||
                    (ix == `FSC_IDX_ECC_IX)  || (ix == `FSC_IDX_CFG)     ||
                    (ix == `FSC_IDX_ERR_CFG) || (ix == `FSC_IDX_STAT)    ||
                    (ix == `FSC_IDX_IRQ_STAT) || (ix == `FSC_IDX_IRQ_CLR);
    endfunction : is_mapped

    // Sticky event bits in interrupt layout
    function automatic logic [2:0] irq_status(input fsc_pkg::fsc_regs_t s);
        irq_status = {s.cmd_done, s.dfd_flag, s.sfd_flag};
    endfunction : irq_status

    // Enable bits in interrupt layout
    function automatic logic [2:0] irq_enable(input fsc_pkg::fsc_regs_t s);
        irq_enable = {s.cfg.cmd_done_irq_enable, s.double_fault_irq_enable, s.single_fault_irq_enable};
    endfunction : irq_enable

    // Read data mux
    function automatic logic [31:0] read_word(input logic [5:0] ix,
                                              input fsc_pkg::fsc_regs_t s);
        logic [31:0] w;
        w = 32'h0;
        unique case (ix)
            `FSC_IDX_SEC:      w[7:0] = s.sec;
            `FSC_IDX_CMD_IX:   w[2:0] = s.cmd_ix;
            `FSC_IDX_ECC_IX:   w[2:0] = s.ecc_ix;
            `FSC_IDX_CFG: begin
                w[`FSC_CFG_CMD_DONE_IRQ_ENABLE]  = s.cfg.cmd_done_irq_enable;
                w[`FSC_CFG_IGNORE_SINGLE_FAULT] = s.cfg.ignore_single_fault;
                w[`FSC_CFG_FORCE_DOUBLE_FAULT]  = s.cfg.force_double_fault;
                w[`FSC_CFG_FORCE_SINGLE_FAULT]  = s.cfg.force_single_fault;
            end
            `FSC_IDX_ERR_CFG:  w[2:0] = irq_enable(s);
            `FSC_IDX_STAT:     w[`FSC_STAT_CMD_DONE] = s.cmd_done;
            `FSC_IDX_IRQ_STAT: w[2:0] = irq_status(s);
            default:           w = 32'h0;
        endcase
        read_word = w;
    endfunction : read_word

    // ======================================================================
    // State

    fsc_pkg::fsc_regs_t regs_r;
    fsc_pkg::fsc_regs_t regs_nxt;

    logic [5:0] acc_ix;
    logic       setup_ph;
    logic       wr_acc;
    logic       ev_dfd;
    logic       ev_sfd;
    logic       upd_dbl;
    logic       upd_sgl;

    // Access decode
    assign acc_ix   = reg_index(PADDR);
    assign setup_ph = PSEL && !PENABLE;
    assign wr_acc   = PSEL && PENABLE && PWRITE;

    // Fault events from the array read path
    assign ev_dfd = RD_VALID && (RD_DBE || regs_r.cfg.force_double_fault);
    assign ev_sfd = RD_VALID && !regs_r.cfg.ignore_single_fault && (RD_SBE || regs_r.cfg.force_single_fault);

    // Result update: a forced fault kind updates only when real
    assign upd_dbl = RD_DBE;
    assign upd_sgl = RD_SBE && !regs_r.cfg.ignore_single_fault;

    // ======================================================================
    // Next-state logic
    always_comb begin
        regs_nxt         = regs_r;
        regs_nxt.launch  = 1'b0;
        regs_nxt.ecc_upd = 1'b0;

        // Reset sequence: load security byte once
        unique case (regs_r.st)
            fsc_pkg::FSC_ST_FETCH: begin
                if (NVM_ACK) begin
                    regs_nxt.sec      = NVM_DBE ? `FSC_SEC_ALL_ONES : NVM_DATA;
                    regs_nxt.st       = fsc_pkg::FSC_ST_READY;
                    regs_nxt.cmd_done = 1'b1;
                end
            end
            fsc_pkg::FSC_ST_READY: begin
            end
        endcase

        // Backdoor unsecure overrides loaded field
        if (BACKDOOR_UNSEC && regs_r.st == fsc_pkg::FSC_ST_READY) begin
            regs_nxt.sec[`FSC_SECF_HI:`FSC_SECF_LO] = `FSC_SEC_UNSECURED;
        end

        // Register writes, taken at the access edge
        if (wr_acc) begin
            unique case (acc_ix)
                `FSC_IDX_CMD_IX:  regs_nxt.cmd_ix = PWDATA[2:0];
                `FSC_IDX_ECC_IX:  regs_nxt.ecc_ix = PWDATA[2:0];
                `FSC_IDX_CFG: begin
                    regs_nxt.cfg.cmd_done_irq_enable  = PWDATA[`FSC_CFG_CMD_DONE_IRQ_ENABLE];
                    regs_nxt.cfg.ignore_single_fault = PWDATA[`FSC_CFG_IGNORE_SINGLE_FAULT];
                    regs_nxt.cfg.force_double_fault  = PWDATA[`FSC_CFG_FORCE_DOUBLE_FAULT];
                    regs_nxt.cfg.force_single_fault  = PWDATA[`FSC_CFG_FORCE_SINGLE_FAULT];
                end
                `FSC_IDX_ERR_CFG: begin
                    regs_nxt.cfg.cmd_done_irq_enable = PWDATA[`FSC_IRQ_CMD];
                    regs_nxt.double_fault_irq_enable    = PWDATA[`FSC_ERR_DFD];
                    regs_nxt.single_fault_irq_enable    = PWDATA[`FSC_ERR_SFD];
                end
                `FSC_IDX_STAT: begin
                    if (PWDATA[`FSC_STAT_CMD_DONE] && regs_r.cmd_done &&
                        regs_r.st == fsc_pkg::FSC_ST_READY) begin
                        regs_nxt.cmd_done = 1'b0;
                        regs_nxt.launch   = 1'b1;
                    end
                end
                `FSC_IDX_IRQ_CLR: begin
                    if (PWDATA[`FSC_ERR_DFD]) begin
                        regs_nxt.dfd_flag = 1'b0;
                    end
                    if (PWDATA[`FSC_ERR_SFD]) begin
                        regs_nxt.sfd_flag = 1'b0;
                    end
                end
                default: begin
                    // Security register and unmapped words ignore writes
                end
            endcase
        end

        // Hardware sets win over software clears
        if (CMD_DONE && regs_r.st == fsc_pkg::FSC_ST_READY) begin
            regs_nxt.cmd_done = 1'b1;
        end
        if (ev_dfd) begin
            regs_nxt.dfd_flag = 1'b1;
        end
        if (ev_sfd) begin
            regs_nxt.sfd_flag = 1'b1;
        end

        // ECC result capture strobe
        if (RD_VALID && (upd_dbl || upd_sgl)) begin
            regs_nxt.ecc_upd = 1'b1;
        end

        // Read data and error captured in the setup phase
        if (setup_ph) begin
            regs_nxt.prdata  = PWRITE ? 32'h0 : read_word(acc_ix, regs_r);
            regs_nxt.pslverr = !is_mapped(acc_ix);
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            regs_r          <= '0;
            regs_r.st       <= fsc_pkg::FSC_ST_FETCH;
            regs_r.sec      <= `FSC_SEC_ALL_ONES;
            regs_r.cmd_ix   <= `FSC_IX_RESET;
            regs_r.ecc_ix   <= `FSC_IX_RESET;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // ======================================================================
    // Outputs

    // APB answers in the first access cycle
    assign PREADY  = 1'b1;
    assign PRDATA  = regs_r.prdata;
    assign PSLVERR = regs_r.pslverr;

    // Security fetch request
    assign NVM_REQ  = (regs_r.st == fsc_pkg::FSC_ST_FETCH);
    assign NVM_ADDR = `FSC_SEC_BYTE_ADDR;

    // Security decode
    assign SECURED     = (regs_r.sec[`FSC_SECF_HI:`FSC_SECF_LO] != `FSC_SEC_UNSECURED);
    assign BACKDOOR_EN = (regs_r.sec[`FSC_BACKDOOR_KEY_ENABLE_HI:`FSC_BACKDOOR_KEY_ENABLE_LO] == `FSC_KEY_ENABLED);

    // Sequencer and result path
    assign CMD_LAUNCH = regs_r.launch;
    assign CMD_INDEX  = regs_r.cmd_ix;
    assign ECC_UPDATE = regs_r.ecc_upd;
    assign ECC_INDEX  = regs_r.ecc_ix;

    // Level interrupt from enabled sticky bits
    assign IRQ = |(irq_status(regs_r) & irq_enable(regs_r));

endmodule : fsc_regs

// ### logic/fsc_map.svh
// Register offsets, field positions, reset values and constants of the flash config block
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define FSC_IDX_SEC        6'h01
`define FSC_IDX_CMD_IX     6'h02
`define FSC_IDX_ECC_IX     6'h03
`define FSC_IDX_CFG        6'h04
`define FSC_IDX_ERR_CFG    6'h05
`define FSC_IDX_STAT       6'h06
`define FSC_IDX_IRQ_STAT   6'h08
`define FSC_IDX_IRQ_CLR    6'h09

// ==========================================================================
// Field positions
`define FSC_BACKDOOR_KEY_ENABLE_HI       7
`define FSC_BACKDOOR_KEY_ENABLE_LO       6
`define FSC_SECF_HI        1
`define FSC_SECF_LO        0
`define FSC_CFG_CMD_DONE_IRQ_ENABLE       7
`define FSC_CFG_IGNORE_SINGLE_FAULT      4
`define FSC_CFG_FORCE_DOUBLE_FAULT       1
`define FSC_CFG_FORCE_SINGLE_FAULT       0
`define FSC_ERR_DFD        1
`define FSC_ERR_SFD        0
`define FSC_IRQ_CMD        2
`define FSC_STAT_CMD_DONE  7

// ==========================================================================
// Values and reset values
`define FSC_KEY_ENABLED    2'h2
`define FSC_SEC_UNSECURED  2'h2
`define FSC_SEC_ALL_ONES   8'hff
`define FSC_IX_RESET       3'h0
`define FSC_SEC_BYTE_ADDR  23'h7fff0f

`endif

// ### logic/fsc_pkg.sv
// Types of the flash security and configuration register block
package fsc_pkg;

    // ======================================================================
    // Reset-sequence states
    typedef enum logic [0:0] {
        FSC_ST_FETCH = 1'b0,
        FSC_ST_READY = 1'b1
    } fsc_state_t;

    // ======================================================================
    // Configuration bits
    typedef struct packed {
        logic cmd_done_irq_enable;
        logic ignore_single_fault;
        logic force_double_fault;
        logic force_single_fault;
    } fsc_cfg_t;

    // ======================================================================
    // Whole block state
    typedef struct packed {
        fsc_state_t  st;
        logic [7:0]  sec;
        logic [2:0]  cmd_ix;
        logic [2:0]  ecc_ix;
        fsc_cfg_t    cfg;
        logic        double_fault_irq_enable;
        logic        single_fault_irq_enable;
        logic        cmd_done;
        logic        dfd_flag;
        logic        sfd_flag;
        logic        launch;
        logic        ecc_upd;
        logic [31:0] prdata;
        logic        pslverr;
    } fsc_regs_t;

endpackage : fsc_pkg

// ### test/fsc_regs_chk.sv
// Port-level assertions for the flash config register block
`timescale 1ns/1ps
module fsc_regs_chk (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        NVM_REQ,
    input wire logic [22:0] NVM_ADDR,
    input wire logic        NVM_ACK,
    input wire logic [7:0]  NVM_DATA,
    input wire logic        NVM_DBE,
    input wire logic        BACKDOOR_UNSEC,
    input wire logic        SECURED,
    input wire logic        BACKDOOR_EN,
    input wire logic        CMD_LAUNCH,
    input wire logic [2:0]  CMD_INDEX,
    input wire logic        RD_VALID,
    input wire logic        RD_SBE,
    input wire logic        RD_DBE,
    input wire logic        ECC_UPDATE
);
    // ====
    // Clocking and reset for every property
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    a_fetch_addr: assert property (NVM_ADDR == 23'h7fff0f)
        else $error("fetch address wrong");
    a_fetch_end: assert property (NVM_REQ && NVM_ACK |=> !NVM_REQ)
        else $error("fetch request stays up");
    a_fetch_dbe: assert property (NVM_REQ && NVM_ACK && NVM_DBE |=> SECURED && !BACKDOOR_EN)
        else $error("double fault fetch not secured");
    a_key_decode: assert property (NVM_REQ && NVM_ACK && !NVM_DBE
        |=> BACKDOOR_EN == (($past(NVM_DATA) & 8'hc0) == 8'h80)) else $error("key enable decode");
    a_sec_decode: assert property (NVM_REQ && NVM_ACK && !NVM_DBE
        |=> SECURED == (($past(NVM_DATA) & 8'h03) != 8'h02)) else $error("security decode");
    a_unsec_force: assert property (BACKDOOR_UNSEC && !NVM_REQ |=> !SECURED)
        else $error("backdoor unsecure ignored");
    a_sec_ro: assert property (PSEL && PENABLE && PWRITE && PADDR[7:2] == 6'h01
        && !BACKDOOR_UNSEC && !NVM_REQ |=> $stable(SECURED) && $stable(BACKDOOR_EN))
        else $error("security written");
    a_cmd_index: assert property (PSEL && PENABLE && PWRITE && PADDR[7:2] == 6'h02
        |=> (32'h0 | CMD_INDEX) == ($past(PWDATA) & 32'h7)) else $error("command index");
    a_idx_upper: assert property (PSEL && PENABLE && !PWRITE && PADDR[7:3] == 5'h01
        |-> PRDATA[31:3] == 29'h0) else $error("index upper bits set");
    a_cfg_upper: assert property (PSEL && PENABLE && !PWRITE && PADDR[7:2] == 6'h04
        |-> (PRDATA & 32'hffffff6c) == 32'h0) else $error("config spare bits set");
    a_ecc_real: assert property (RD_VALID && RD_DBE |=> ECC_UPDATE)
        else $error("real double fault not captured");
    a_ecc_none: assert property (RD_VALID && !RD_DBE && !RD_SBE |=> !ECC_UPDATE)
        else $error("capture without fault");
    a_launch_once: assert property (CMD_LAUNCH |=> !CMD_LAUNCH)
        else $error("launch longer than a cycle");
endmodule : fsc_regs_chk

bind fsc_regs fsc_regs_chk fsc_regs_chk_i (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .NVM_REQ(NVM_REQ), .NVM_ADDR(NVM_ADDR), .NVM_ACK(NVM_ACK), .NVM_DATA(NVM_DATA),
    .NVM_DBE(NVM_DBE), .BACKDOOR_UNSEC(BACKDOOR_UNSEC), .SECURED(SECURED),
    .BACKDOOR_EN(BACKDOOR_EN), .CMD_LAUNCH(CMD_LAUNCH), .CMD_INDEX(CMD_INDEX),
    .RD_VALID(RD_VALID), .RD_SBE(RD_SBE), .RD_DBE(RD_DBE), .ECC_UPDATE(ECC_UPDATE));

// ### test/fsc_flash_model.sv
// Flash array read path and security byte source for the bench
`timescale 1ns/1ps
module fsc_flash_model (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        NVM_REQ,
    input  wire logic [22:0] NVM_ADDR,
    output logic             NVM_ACK,
    output logic      [7:0]  NVM_DATA,
    output logic             NVM_DBE,
    output logic             RD_VALID,
    output logic             RD_SBE,
    output logic             RD_DBE
);
    // Stored byte: key 10, spare bits left erased, field 01
    logic [7:0] sec_byte  = 8'hbd;
    logic       fetch_dbe = 1'b0;
    logic [1:0] wait_cnt;

    // Idle read strobes
    initial begin
        RD_VALID = 1'b0;
        RD_SBE   = 1'b0;
        RD_DBE   = 1'b0;
    end

    // Slow fetch answer; data shown only in the acknowledge cycle
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wait_cnt <= 2'h0;
            NVM_ACK  <= 1'b0;
            NVM_DATA <= 8'h00;
            NVM_DBE  <= 1'b0;
        end else begin
            wait_cnt <= NVM_REQ ? wait_cnt + 2'h1 : 2'h0;
            NVM_ACK  <= NVM_REQ && wait_cnt == 2'h3 && NVM_ADDR == 23'h7fff0f;
            NVM_DATA <= (wait_cnt == 2'h3) ? sec_byte : ~NVM_DATA;
            NVM_DBE  <= (wait_cnt == 2'h3) ? fetch_dbe : ~NVM_DBE;
        end
    end

    // One array read with the given real faults
    task automatic do_read(input logic sbe, input logic dbe);
        RD_VALID <= 1'b1;
        RD_SBE   <= sbe;
        RD_DBE   <= dbe;
        @(posedge CLK);
        RD_VALID <= 1'b0;
        RD_SBE   <= ~sbe;
        RD_DBE   <= ~dbe;
    endtask : do_read
endmodule : fsc_flash_model

// ### test/tb.sv
// Self-checking bench for the flash config register block
`timescale 1ns/1ps
`include "fsc_map.svh"
module tb;
    logic        CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, NVM_REQ, NVM_ACK, NVM_DBE;
    logic        BACKDOOR_UNSEC, SECURED, BACKDOOR_EN, CMD_LAUNCH, CMD_DONE, IRQ;
    logic        RD_VALID, RD_SBE, RD_DBE, ECC_UPDATE;
    logic [7:0]  PADDR, NVM_DATA;
    logic [31:0] PWDATA, PRDATA;
    logic [22:0] NVM_ADDR;
    logic [2:0]  CMD_INDEX, ECC_INDEX;
    int          mismatches = 0, tests_run = 0, ecc_cnt = 0, launch_cnt = 0;

    fsc_regs fsc_regs_i (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .NVM_REQ(NVM_REQ), .NVM_ADDR(NVM_ADDR), .NVM_ACK(NVM_ACK),
        .NVM_DATA(NVM_DATA), .NVM_DBE(NVM_DBE), .BACKDOOR_UNSEC(BACKDOOR_UNSEC),
        .SECURED(SECURED), .BACKDOOR_EN(BACKDOOR_EN), .CMD_LAUNCH(CMD_LAUNCH),
        .CMD_DONE(CMD_DONE), .CMD_INDEX(CMD_INDEX), .RD_VALID(RD_VALID), .RD_SBE(RD_SBE),
        .RD_DBE(RD_DBE), .ECC_UPDATE(ECC_UPDATE), .ECC_INDEX(ECC_INDEX), .IRQ(IRQ));
    fsc_flash_model fsc_flash_model_i (.CLK(CLK), .RSTN(RSTN), .NVM_REQ(NVM_REQ),
        .NVM_ADDR(NVM_ADDR), .NVM_ACK(NVM_ACK), .NVM_DATA(NVM_DATA), .NVM_DBE(NVM_DBE),
        .RD_VALID(RD_VALID), .RD_SBE(RD_SBE), .RD_DBE(RD_DBE));

    // ====
    // 40 MHz clock
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    // Count capture and launch pulses
    always @(posedge CLK) begin
        if (ECC_UPDATE === 1'b1) ecc_cnt++;
        if (CMD_LAUNCH === 1'b1) launch_cnt++;
    end

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until ready
    task automatic apb(input logic w, input logic [5:0] ix, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= {ix, 2'b00};
        PWDATA  <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask : apb

    task automatic wr(input logic [5:0] ix, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, ix, d, r, e);
    endtask : wr

    task automatic rd(input logic [5:0] ix, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, ix, 32'h0, r, e);
        chk({e, r}, {1'b0, exp});
    endtask : rd

    task automatic do_reset(input logic dbe);
        fsc_flash_model_i.fetch_dbe = dbe;
        RSTN <= 1'b0;
        repeat (12) @(posedge CLK);
        RSTN <= 1'b1;
        do @(posedge CLK); while (NVM_REQ !== 1'b0);
        @(posedge CLK);
    endtask : do_reset

    task automatic t_reset_vals();
        do_reset(1'b0);
        rd(`FSC_IDX_SEC, 32'hbd);
        chk(33'(SECURED), 33'h1);
        chk(33'(BACKDOOR_EN), 33'h1);
        rd(`FSC_IDX_CMD_IX, 32'h0);
        rd(`FSC_IDX_ECC_IX, 32'h0);
        rd(`FSC_IDX_CFG, 32'h0);
    endtask : t_reset_vals

    task automatic t_security();
        wr(`FSC_IDX_SEC, 32'h0);
        rd(`FSC_IDX_SEC, 32'hbd);
        BACKDOOR_UNSEC <= 1'b1;
        @(posedge CLK);
        BACKDOOR_UNSEC <= 1'b0;
        @(posedge CLK);
        rd(`FSC_IDX_SEC, 32'hbe);
        chk(33'(SECURED), 33'h0);
    endtask : t_security

    task automatic t_fields();
        logic [31:0] r;
        logic        e;
        wr(`FSC_IDX_CMD_IX, 32'hff);
        rd(`FSC_IDX_CMD_IX, 32'h7);
        chk(33'(CMD_INDEX), 33'h7);
        wr(`FSC_IDX_ECC_IX, 32'hff);
        rd(`FSC_IDX_ECC_IX, 32'h7);
        chk(33'(ECC_INDEX), 33'h7);
        wr(`FSC_IDX_CFG, 32'hff);
        rd(`FSC_IDX_CFG, 32'h93);
        wr(`FSC_IDX_CFG, 32'h0);
        rd(`FSC_IDX_CFG, 32'h0);
        apb(1'b0, 6'h07, 32'h0, r, e);
        chk({e, r}, {1'b1, 32'h0});
    endtask : t_fields

    task automatic fault_case(input logic [7:0] cfg, input logic sbe, input logic dbe,
                              input logic [1:0] en, input logic [1:0] st, input logic upd);
        logic [31:0] r;
        logic        e;
        int          n;
        wr(`FSC_IDX_CFG, {24'h0, cfg});
        wr(`FSC_IDX_ERR_CFG, {30'h0, en});
        wr(`FSC_IDX_IRQ_CLR, 32'h3);
        n = ecc_cnt;
        fsc_flash_model_i.do_read(sbe, dbe);
        repeat (2) @(posedge CLK);
        apb(1'b0, `FSC_IDX_IRQ_STAT, 32'h0, r, e);
        chk({31'h0, r[1:0]}, {31'h0, st});
        chk(33'(IRQ), 33'(|(st & en)));
        chk(33'(ecc_cnt - n), 33'(upd));
    endtask : fault_case

    task automatic t_faults();
        fault_case(8'h00, 1'b0, 1'b0, 2'h3, 2'h0, 1'b0);
        fault_case(8'h02, 1'b0, 1'b0, 2'h3, 2'h2, 1'b0);
        fault_case(8'h01, 1'b0, 1'b0, 2'h3, 2'h1, 1'b0);
        fault_case(8'h02, 1'b0, 1'b1, 2'h3, 2'h2, 1'b1);
        fault_case(8'h01, 1'b1, 1'b0, 2'h3, 2'h1, 1'b1);
        fault_case(8'h11, 1'b1, 1'b0, 2'h3, 2'h0, 1'b0);
        fault_case(8'h00, 1'b1, 1'b0, 2'h0, 2'h1, 1'b1);
        fault_case(8'h00, 1'b0, 1'b1, 2'h2, 2'h2, 1'b1);
    endtask : t_faults

    task automatic t_command();
        int n;
        wr(`FSC_IDX_ERR_CFG, 32'h0);
        wr(`FSC_IDX_IRQ_CLR, 32'h3);
        wr(`FSC_IDX_CFG, 32'h80);
        chk(33'(IRQ), 33'h1);
        n = launch_cnt;
        wr(`FSC_IDX_STAT, 32'h80);
        @(posedge CLK);
        chk(33'(launch_cnt - n), 33'h1);
        rd(`FSC_IDX_STAT, 32'h0);
        chk(33'(IRQ), 33'h0);
        CMD_DONE <= 1'b1;
        @(posedge CLK);
        CMD_DONE <= 1'b0;
        @(posedge CLK);
        rd(`FSC_IDX_STAT, 32'h80);
        chk(33'(IRQ), 33'h1);
        wr(`FSC_IDX_CFG, 32'h0);
        chk(33'(IRQ), 33'h0);
    endtask : t_command

    task automatic t_dbe_fetch();
        do_reset(1'b1);
        rd(`FSC_IDX_SEC, 32'hff);
        chk(33'(SECURED), 33'h1);
        chk(33'(BACKDOOR_EN), 33'h0);
    endtask : t_dbe_fetch

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        RSTN = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        BACKDOOR_UNSEC = 1'b0;
        CMD_DONE = 1'b0;
        t_reset_vals();
        t_security();
        t_fields();
        t_faults();
        t_command();
        t_dbe_fetch();
        end_of_test();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        end_of_test();
    end
endmodule : tb
